// [hw/atp_timer.sv]
// absent-pulse delay and measured-cycle registers of the angular timer, Wishbone classic slave
`include "atp_defines.svh"

// What this block does
// - The absent-pulse delay is a 16-bit two's-complement value written as a high byte and a low byte.
// - The missing-pulse output goes valid once running count minus latched cycle length reaches the delay.
// - A high-byte write waits in a buffer and loads together with the next low-byte write.
// - The measured cycle length is a read-only 15-bit value, upper seven bits high, lower eight bits low.
module atp_timer #(
    parameter int ADDR_W  = `ATP_ADDR_W,
    parameter int DELAY_W = `ATP_DELAY_W,
    parameter int CYCLE_W = `ATP_CYCLE_W
) (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     ce_i,
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [ADDR_W-1:0]        wb_adr_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic [`ATP_DATA_W-1:0]   wb_dat_i,
    output logic      [`ATP_DATA_W-1:0]   wb_dat_o,
    output logic                          wb_ack_o,
    input  wire logic                     pulse_i,
    output logic                          pulse_missing_o,
    output logic                          irq_o
);
    import atp_pkg::*;

    // bus decode
    wire logic                     bus_req   = wb_cyc_i & wb_stb_i;
    wire logic                     req_first = bus_req & ~wb_ack_o;
    wire logic                     req_done  = bus_req & wb_ack_o;
    wire logic                     lane0     = wb_sel_i[0];
    wire logic [ADDR_W-3:0]        word_adr  = wb_adr_i[ADDR_W-1:2];

    wire logic hit_dly_hi = (word_adr == (ADDR_W-2)'(`ATP_OFF_DELAY_HIGH >> 2));
    wire logic hit_dly_lo = (word_adr == (ADDR_W-2)'(`ATP_OFF_DELAY_LOW >> 2));
    wire logic hit_cyc_hi = (word_adr == (ADDR_W-2)'(`ATP_OFF_CYCLE_HIGH >> 2));
    wire logic hit_cyc_lo = (word_adr == (ADDR_W-2)'(`ATP_OFF_CYCLE_LOW >> 2));
    wire logic hit_status = (word_adr == (ADDR_W-2)'(`ATP_OFF_IRQ_STATUS >> 2));
    wire logic hit_mask   = (word_adr == (ADDR_W-2)'(`ATP_OFF_IRQ_MASK >> 2));

    // writes take effect at the edge where the master sees ack
    wire logic wr_commit  = req_done & wb_we_i & lane0;
    wire logic wr_dly_hi  = wr_commit & hit_dly_hi;
    wire logic wr_dly_lo  = wr_commit & hit_dly_lo;
    wire logic wr_mask    = wr_commit & hit_mask;
    wire logic rd_status  = req_done & ~wb_we_i & hit_status;

    // delay registers
    atp_byte_t                 dly_hi_buf_q;
    logic      [DELAY_W-1:0]   delay_q;
    atp_byte_t                 wr_byte;

    assign wr_byte = wb_dat_i[7:0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dly_hi_buf_q <= atp_byte_t'(`ATP_DELAY_RESET >> 8);
            delay_q      <= `ATP_DELAY_RESET;
        end else if (ce_i) begin
            if (wr_dly_hi) begin
                dly_hi_buf_q <= wr_byte;
            end
            if (wr_dly_lo) begin
                delay_q <= {dly_hi_buf_q, wr_byte};
            end
        end
    end

    // input edge and measurement state
    logic                      pulse_prev_q;
    atp_meas_state_t           meas_state_q;
    atp_meas_state_t           meas_state_d;
    wire logic                 pulse_edge = pulse_i & ~pulse_prev_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pulse_prev_q <= 1'b0;
            meas_state_q <= ATP_IDLE;
        end else if (ce_i) begin
            pulse_prev_q <= pulse_i;
            meas_state_q <= meas_state_d;
        end
    end

    // first edge only starts a measurement, the second one gives a length
    always_comb begin
        meas_state_d = meas_state_q;
        case (meas_state_q)
            ATP_IDLE: begin
                if (pulse_edge) begin
                    meas_state_d = ATP_ARMED;
                end
            end
            ATP_ARMED: begin
                if (pulse_edge) begin
                    meas_state_d = ATP_VALID;
                end
            end
            ATP_VALID: begin
                meas_state_d = ATP_VALID;
            end
            default: begin
                meas_state_d = ATP_IDLE;
            end
        endcase
    end

    // period counter
    logic [CYCLE_W-1:0] run_count;
    logic               run_wrapped;

    atp_cycle_counter #(
        .W(CYCLE_W)
    ) u_counter (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .restart_i (pulse_edge),
        .count_o   (run_count),
        .wrapped_o (run_wrapped)
    );

    // latched cycle length
    logic [CYCLE_W-1:0] cycle_q;
    logic               cycle_ovf_q;
    wire logic          latch_cycle = pulse_edge & (meas_state_q != ATP_IDLE);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cycle_q     <= `ATP_CYCLE_RESET;
            cycle_ovf_q <= 1'b0;
        end else if (ce_i && latch_cycle) begin
            cycle_q     <= run_count;
            cycle_ovf_q <= run_wrapped;
        end
    end

    // signed distance from the last cycle length; a wrapped count is always late
    wire logic [DELAY_W-1:0] cnt_ext   = {{(DELAY_W-CYCLE_W){1'b0}}, run_count};
    wire logic [DELAY_W-1:0] cyc_ext   = {{(DELAY_W-CYCLE_W){1'b0}}, cycle_q};
    wire logic [DELAY_W-1:0] distance  = cnt_ext - cyc_ext;
    wire logic               reached   = ($signed(distance) >= $signed(delay_q)) | run_wrapped;
    wire logic               miss_cond = (meas_state_q == ATP_VALID) & ~pulse_edge & reached;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pulse_missing_o <= 1'b0;
        end else if (ce_i) begin
            pulse_missing_o <= miss_cond;
        end
    end

    // interrupt status, cleared by reading it; only bits actually returned are cleared
    logic [`ATP_EVENT_W-1:0] status_q;
    logic [`ATP_EVENT_W-1:0] mask_q;
    logic [`ATP_EVENT_W-1:0] events;
    wire logic [`ATP_EVENT_W-1:0] rd_clear = rd_status ? wb_dat_o[`ATP_EVENT_W-1:0] : '0;

    always_comb begin
        events = '0;
        events[`ATP_EV_PERIOD_BIT]   = latch_cycle;
        events[`ATP_EV_MISSING_BIT]  = miss_cond & ~pulse_missing_o;
        events[`ATP_EV_OVERFLOW_BIT] = latch_cycle & run_wrapped;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_q <= '0;
            mask_q   <= `ATP_MASK_RESET;
            irq_o    <= 1'b0;
        end else if (ce_i) begin
            status_q <= (status_q & ~rd_clear) | events;
            if (wr_mask) begin
                mask_q <= wb_dat_i[`ATP_EVENT_W-1:0];
            end
            irq_o <= |(((status_q & ~rd_clear) | events) & (wr_mask ? wb_dat_i[`ATP_EVENT_W-1:0] : mask_q));
        end
    end

    // read mux; data is captured at the same edge that raises ack so it stands while ack is high
    atp_byte_t rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        if (hit_dly_hi) begin
            rd_byte = delay_q[15:8];
        end else if (hit_dly_lo) begin
            rd_byte = delay_q[7:0];
        end else if (hit_cyc_hi) begin
            rd_byte = {cycle_ovf_q, cycle_q[14:8]};
        end else if (hit_cyc_lo) begin
            rd_byte = cycle_q[7:0];
        end else if (hit_status) begin
            rd_byte = {{(8-`ATP_EVENT_W){1'b0}}, status_q};
        end else if (hit_mask) begin
            rd_byte = {{(8-`ATP_EVENT_W){1'b0}}, mask_q};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else if (ce_i) begin
            wb_ack_o <= req_first;
            if (req_first) begin
                wb_dat_o <= {24'h000000, rd_byte};
            end
        end
    end

    // checks
    property p_delay_pair_load;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && wr_dly_lo) |=> (delay_q == {$past(dly_hi_buf_q), $past(wr_byte)});
    endproperty
    a_delay_pair_load: assert property (p_delay_pair_load) else $error("delay not loaded as buffered pair");

    property p_high_held;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && wr_dly_hi && !wr_dly_lo) |=> (delay_q == $past(delay_q)) && (dly_hi_buf_q == $past(wr_byte));
    endproperty
    a_high_held: assert property (p_high_held) else $error("high byte write reached delay early");

    property p_missing_follows;
        @(posedge clk_i) disable iff (rst_i)
        ce_i |=> (pulse_missing_o == $past(miss_cond)) || !$past(ce_i);
    endproperty
    a_missing_follows: assert property (p_missing_follows) else $error("missing output wrong");

    property p_missing_needs_delay;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && pulse_missing_o && !$past(pulse_missing_o) && $past(ce_i))
            |-> ($past(run_wrapped) || ($signed($past(distance)) >= $signed($past(delay_q))));
    endproperty
    a_missing_needs_delay: assert property (p_missing_needs_delay) else $error("missing before delay");

    property p_cycle_latch;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && latch_cycle) |=> (cycle_q == $past(run_count));
    endproperty
    a_cycle_latch: assert property (p_cycle_latch) else $error("cycle length not latched");

    property p_overflow_flag;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && latch_cycle) |=> (cycle_ovf_q == $past(run_wrapped))
            && (!$past(run_wrapped) || status_q[`ATP_EV_OVERFLOW_BIT]);
    endproperty
    a_overflow_flag: assert property (p_overflow_flag) else $error("overflow flag wrong");

    property p_ack_single;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && wb_ack_o) |=> !wb_ack_o;
    endproperty
    a_ack_single: assert property (p_ack_single) else $error("ack held longer than one cycle");

    property p_ack_answers;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && req_first) |=> wb_ack_o;
    endproperty
    a_ack_answers: assert property (p_ack_answers) else $error("request not acknowledged");

    property p_read_upper_zero;
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |-> (wb_dat_o[`ATP_DATA_W-1:8] == '0);
    endproperty
    a_read_upper_zero: assert property (p_read_upper_zero) else $error("read data upper bits not zero");

    property p_delay_only_on_low;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && !wr_dly_lo) |=> (delay_q == $past(delay_q));
    endproperty
    a_delay_only_on_low: assert property (p_delay_only_on_low) else $error("delay changed without low write");

    property p_cycle_read_only;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && !latch_cycle) |=> (cycle_q == $past(cycle_q)) && (cycle_ovf_q == $past(cycle_ovf_q));
    endproperty
    a_cycle_read_only: assert property (p_cycle_read_only) else $error("cycle length changed off an edge");

    property p_missing_drops_on_edge;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && pulse_edge) |=> !pulse_missing_o;
    endproperty
    a_missing_drops_on_edge: assert property (p_missing_drops_on_edge) else $error("missing kept after edge");

    property p_irq_level;
        @(posedge clk_i) disable iff (rst_i)
        ce_i |=> (irq_o == |(status_q & mask_q));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq does not follow masked status");

    property p_period_set_wins;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && latch_cycle) |=> status_q[`ATP_EV_PERIOD_BIT];
    endproperty
    a_period_set_wins: assert property (p_period_set_wins) else $error("period event lost");

    property p_enable_freezes;
        @(posedge clk_i) disable iff (rst_i)
        !ce_i |=> (run_count == $past(run_count)) && (wb_ack_o == $past(wb_ack_o))
            && (pulse_missing_o == $past(pulse_missing_o)) && (meas_state_q == $past(meas_state_q));
    endproperty
    a_enable_freezes: assert property (p_enable_freezes) else $error("state moved with enable low");
endmodule

// [hw/atp_defines.svh]
// register map, field positions, reset values and widths of the absent-pulse timer slice
`ifndef ATP_DEFINES_SVH
`define ATP_DEFINES_SVH

`define ATP_ADDR_W          8
`define ATP_DATA_W          32

`define ATP_OFF_DELAY_HIGH  8'h00
`define ATP_OFF_DELAY_LOW   8'h04
`define ATP_OFF_CYCLE_HIGH  8'h08
`define ATP_OFF_CYCLE_LOW   8'h0C
`define ATP_OFF_IRQ_STATUS  8'h10
`define ATP_OFF_IRQ_MASK    8'h14

`define ATP_DELAY_W         16
`define ATP_CYCLE_W         15
`define ATP_EVENT_W         3

`define ATP_EV_PERIOD_BIT   0
`define ATP_EV_MISSING_BIT  1
`define ATP_EV_OVERFLOW_BIT 2

`define ATP_DELAY_RESET     16'h0000
`define ATP_CYCLE_RESET     15'h0000
`define ATP_MASK_RESET      3'h0

`endif

// [hw/atp_pkg.sv]
// types shared by the absent-pulse timer slice
package atp_pkg;
    typedef logic [7:0] atp_byte_t;

    typedef enum {
        ATP_IDLE,
        ATP_ARMED,
        ATP_VALID
    } atp_meas_state_t;
endpackage

// [hw/atp_cycle_counter.sv]
// free-running cycle counter with restart and sticky wrap flag
module atp_cycle_counter #(
    parameter int W = 15
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    input  wire logic         restart_i,
    output logic      [W-1:0] count_o,
    output logic              wrapped_o
);
    import atp_pkg::*;

    wire logic at_top = &count_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_o   <= '0;
            wrapped_o <= 1'b0;
        end else if (ce_i) begin
            if (restart_i) begin
                count_o   <= '0;
                wrapped_o <= 1'b0;
            end else begin
                count_o   <= count_o + 1'b1;
                wrapped_o <= wrapped_o | at_top;
            end
        end
    end
endmodule

// [sim/testbench.sv]
// self-checking bench for the absent-pulse delay and measured-cycle registers
`include "atp_defines.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import atp_pkg::*;

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        ce_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        pulse_i = 1'b0;
    logic        pulse_missing_o;
    logic        irq_o;
    int          n_fail = 0;
    int          checked = 0;
    logic [31:0] q;

    always #2.5 clk_i = ~clk_i;

    atp_timer i_atp_timer (
        .clk_i           (clk_i),
        .rst_i           (rst_i),
        .ce_i            (ce_i),
        .wb_cyc_i        (wb_cyc_i),
        .wb_stb_i        (wb_stb_i),
        .wb_we_i         (wb_we_i),
        .wb_adr_i        (wb_adr_i),
        .wb_sel_i        (wb_sel_i),
        .wb_dat_i        (wb_dat_i),
        .wb_dat_o        (wb_dat_o),
        .wb_ack_o        (wb_ack_o),
        .pulse_i         (pulse_i),
        .pulse_missing_o (pulse_missing_o),
        .irq_o           (irq_o)
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one classic cycle; request held until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) check("ack", 32'h0, 32'h1);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
    endtask

    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 8'h00, q);
        check(what, q, exp);
    endtask

    // k input edges, each n cycles after the previous one
    task automatic pulses(input int n, input int k);
        repeat (k) begin
            repeat (n - 2) @(posedge clk_i);
            @(posedge clk_i);
            pulse_i <= 1'b1;
            @(posedge clk_i);
            pulse_i <= 1'b0;
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge clk_i);
        n_fail++;
        summarize();
    end

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rd("delay_high", `ATP_OFF_DELAY_HIGH, 32'h0);
        rd("delay_low", `ATP_OFF_DELAY_LOW, 32'h0);
        rd("cycle_high", `ATP_OFF_CYCLE_HIGH, 32'h0);
        rd("cycle_low", `ATP_OFF_CYCLE_LOW, 32'h0);
        rd("unmapped", 8'h18, 32'h0);
        $display("test reset done");
        // high byte waits in the buffer until the low byte lands
        wr(`ATP_OFF_DELAY_HIGH, 8'h12);
        rd("delay_high_buffered", `ATP_OFF_DELAY_HIGH, 32'h0);
        wr(`ATP_OFF_DELAY_LOW, 8'h34);
        rd("delay_high_loaded", `ATP_OFF_DELAY_HIGH, 32'h12);
        rd("delay_low_loaded", `ATP_OFF_DELAY_LOW, 32'h34);
        wr(`ATP_OFF_CYCLE_LOW, 8'h55);
        rd("cycle_low_ro", `ATP_OFF_CYCLE_LOW, 32'h0);
        $display("test delay pair done");
        wr(`ATP_OFF_DELAY_HIGH, 8'h00);
        wr(`ATP_OFF_DELAY_LOW, 8'h05);
        pulses(300, 3);
        rd("cycle_low_299", `ATP_OFF_CYCLE_LOW, 32'h2B);
        rd("cycle_high_299", `ATP_OFF_CYCLE_HIGH, 32'h01);
        check("irq_masked", {31'h0, irq_o}, 32'h0);
        rd("status_latched", `ATP_OFF_IRQ_STATUS, 32'h01);
        wr(`ATP_OFF_IRQ_MASK, 8'h07);
        rd("mask", `ATP_OFF_IRQ_MASK, 32'h07);
        $display("test measure done");
        // delay +5 past a 299 cycle length: absent near count 304
        pulses(300, 2);
        repeat (250) @(posedge clk_i);
        check("missing_early", {31'h0, pulse_missing_o}, 32'h0);
        repeat (70) @(posedge clk_i);
        check("missing_late", {31'h0, pulse_missing_o}, 32'h1);
        check("irq_on", {31'h0, irq_o}, 32'h1);
        rd("status_missing", `ATP_OFF_IRQ_STATUS, 32'h03);
        repeat (2) @(posedge clk_i);
        check("irq_cleared", {31'h0, irq_o}, 32'h0);
        $display("test positive delay done");
        // negative delay -10 fires before the full length
        wr(`ATP_OFF_DELAY_HIGH, 8'hFF);
        wr(`ATP_OFF_DELAY_LOW, 8'hF6);
        pulses(300, 2);
        repeat (2) @(posedge clk_i);
        check("missing_cleared", {31'h0, pulse_missing_o}, 32'h0);
        repeat (248) @(posedge clk_i);
        check("missing_neg_early", {31'h0, pulse_missing_o}, 32'h0);
        repeat (50) @(posedge clk_i);
        check("missing_neg_late", {31'h0, pulse_missing_o}, 32'h1);
        $display("test negative delay done");
        // spacing beyond the 15-bit range wraps the counter
        pulses(33000, 1);
        rd("status_pre", `ATP_OFF_IRQ_STATUS, 32'h07);
        wb(1'b0, `ATP_OFF_CYCLE_HIGH, 8'h00, q);
        check("overflow_flag", {31'h0, q[7]}, 32'h1);
        $display("test overflow done");
        // 50 frozen cycles inside a 250 cycle spacing leave a length of 199
        pulses(200, 1);
        ce_i <= 1'b0;
        repeat (50) @(posedge clk_i);
        ce_i <= 1'b1;
        pulses(200, 1);
        rd("cycle_low_frozen", `ATP_OFF_CYCLE_LOW, 32'hC7);
        rd("cycle_high_frozen", `ATP_OFF_CYCLE_HIGH, 32'h00);
        $display("test enable freeze done");
        summarize();
    end
endmodule
